// ===== hdl/qd_consts.svh
// Purpose: constants of the quad DAC serial control block
// Assumes: 200 MHz system clock
// Notes:   offsets are byte addresses on the register bus
`ifndef QD_CONSTS_SVH
`define QD_CONSTS_SVH
// ***************************************
// Frame layout
// ***************************************
`define QD_FRAME_BITS   5'd16
`define QD_RD_START     5'd4
`define QD_RW_BIT       15
`define QD_SEL_HI       14
`define QD_SEL_LO       12
`define QD_SEL_NOP      3'h0
`define QD_SEL_ALL      3'h5
`define QD_SEL_CTRL     3'h7
// ***************************************
// Control word fields and reset values
// ***************************************
`define QD_CB_THERM     0
`define QD_CB_PWR_LO    2
`define QD_CB_PWR_HI    5
`define QD_CB_FLOAT     6
`define QD_CTRL_RESET   7'h40
`define QD_CODE_RESET   12'h000
`define QD_SPAN_RESET   4'hF
// ***************************************
// Timing
// ***************************************
`define QD_CLK_MHZ       200
`define QD_SYNC_HIGH_NS  20
`define QD_SYNC_HIGH_CYC ((`QD_SYNC_HIGH_NS * `QD_CLK_MHZ + 999) / 1000)
// ***************************************
// Register bus map
// ***************************************
`define QD_OFS_STATUS   8'h00
`define QD_OFS_CTRL     8'h04
`define QD_OFS_DAC0     8'h10
`define QD_OFS_INP0     8'h20
`define QD_OFS_CWORD    8'h30
`define QD_SW_CTRL_RST  2'h1
`endif

// ===== hdl/qd_dac_ctrl.sv
// Purpose: serial control logic of a four channel 12-bit DAC
// Assumes: serial pins asynchronous to clock, sampled twice
// Notes:   clear and load edges are found after synchronising
`timescale 1ns/100ps
`include "qd_consts.svh"
module qd_dac_ctrl (
    input  wire logic                  clock,
    input  wire logic                  rst_b,
    input  wire logic [7:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    input  wire logic                  frame_sel_n,
    input  wire logic                  serial_clk,
    input  wire logic                  serial_din,
    output logic                       serial_dout,
    output logic                       serial_dout_oe,
    input  wire logic                  async_clear_n,
    input  wire logic                  load_dac_n,
    input  wire logic                  range_sel,
    input  wire logic                  over_temp,
    output logic                       alarm_n,
    output qd_pkg::qd_code_t [3:0]     dac_code,
    output logic      [3:0]            span_30v,
    output logic      [3:0]            chan_on,
    output logic                       output_float_select
);
    import qd_pkg::*;

    // ***************************************
    // Pin synchronisation and edges
    // ***************************************
    logic [6:0] pins_s;
    logic       fs_n, sclk, din, clear_n, ld_n, rsel, ot;
    logic       sclk_q, fs_q, clear_q, ld_q;
    logic       sclk_rise, sclk_fall, fs_fall, clear_fall, ld_fall;
    qd_sync #(
        .W   (7),
        .RST (7'h4E)
    ) u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .d     ({frame_sel_n, serial_clk, serial_din, async_clear_n,
                 load_dac_n, range_sel, over_temp}),
        .q     (pins_s)
    );

    // Unpack synchronised pins
    assign fs_n  = pins_s[6];
    assign sclk  = pins_s[5];
    assign din   = pins_s[4];
    assign clear_n = pins_s[3];
    assign ld_n  = pins_s[2];
    assign rsel  = pins_s[1];
    assign ot    = pins_s[0];

    // Previous levels for edge detection
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {sclk_q, fs_q, clear_q, ld_q} <= 4'h7;
        end else begin
            {sclk_q, fs_q, clear_q, ld_q} <= {sclk, fs_n, clear_n, ld_n};
        end
    end

    // Edge strobes, one cycle each
    assign sclk_rise = sclk & ~sclk_q;
    assign sclk_fall = ~sclk & sclk_q;
    assign fs_fall   = ~fs_n & fs_q;
    assign clear_fall = ~clear_n & clear_q;
    assign ld_fall   = ~ld_n & ld_q;

    // ***************************************
    // Frame tracking
    // ***************************************
    qd_frame_t   state;
    logic [4:0]  bit_cnt;
    logic [15:0] sh;
    logic [2:0]  hi_cnt;
    logic        armed, start, exec, link_en, temp_test, rw;
    qd_sel_t     sel;
    qd_code_t    wdata;
    // Count cycles of select high before a new frame may open
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            hi_cnt <= 3'h0;
        end else if (!fs_n) begin
            hi_cnt <= 3'h0;
        end else if (!armed) begin
            hi_cnt <= hi_cnt + 3'h1;
        end
    end

    assign armed = hi_cnt >= 3'(`QD_SYNC_HIGH_CYC);
    assign start = fs_fall & armed & link_en;
    assign exec  = (state == QD_SHIFT) & ~fs_n & sclk_fall
                 & (bit_cnt == `QD_FRAME_BITS);
    assign rw    = sh[`QD_RW_BIT];
    assign sel   = sh[`QD_SEL_HI:`QD_SEL_LO];
    assign wdata = sh[11:0];

    // Frame state; no clock edge is expected outside a frame
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state <= QD_IDLE;
        end else begin
            case (state)
                QD_IDLE: begin
                    if (start) begin
                        state <= QD_SHIFT;
                    end
                end
                QD_SHIFT: begin
                    if (fs_n) begin
                        state <= QD_IDLE;
                    end else if (exec) begin
                        state <= QD_HOLD;
                    end
                end
                QD_HOLD: begin
                    if (fs_n) begin
                        state <= QD_IDLE;
                    end
                end
                default: begin
                    state <= QD_IDLE;
                end
            endcase
        end
    end

    // Shift register, most significant bit first on each rise
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bit_cnt <= 5'h0;
            sh      <= 16'h0000;
        end else if (start) begin
            bit_cnt <= 5'h0;
        end else if (state == QD_SHIFT && sclk_rise && bit_cnt != `QD_FRAME_BITS) begin
            sh      <= {sh[14:0], din};
            bit_cnt <= bit_cnt + 5'h1;
        end
    end

    // ***************************************
    // Register file of the converter
    // ***************************************
    qd_code_t [3:0] in_reg;
    qd_code_t [3:0] dac_reg;
    logic     [3:0] wr_hit;
    logic     [6:0] ctrl;
    logic           ctrl_wr, therm_set, therm_clear, next_therm, dac_upd;
    // Channels addressed by a write frame
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_hit[i] = exec && !rw
                && (sel == 3'(i + 1) || sel == `QD_SEL_ALL);
        end
    end

    // Input registers, cleared by reset or clear pin
    always_ff @(posedge clock) begin
        if (!rst_b || clear_fall) begin
            in_reg <= {4{`QD_CODE_RESET}};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_hit[i]) begin
                    in_reg[i] <= wdata;
                end
            end
        end
    end

    // Output registers: load edge copies all, load low updates addressed
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dac_reg  <= {4{`QD_CODE_RESET}};
            span_30v <= `QD_SPAN_RESET;
        end else if (clear_fall) begin
            dac_reg <= {4{`QD_CODE_RESET}};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (ld_fall) begin
                    dac_reg[i] <= in_reg[i];
                    span_30v[i] <= rsel;
                end else if (wr_hit[i] && !ld_n) begin
                    dac_reg[i] <= wdata;
                    span_30v[i] <= rsel;
                end
            end
        end
    end

    assign dac_code  = dac_reg;
    assign ctrl_wr   = exec && !rw && sel == `QD_SEL_CTRL;
    assign therm_set = ot | temp_test;
    assign therm_clear = ctrl_wr && !wdata[`QD_CB_THERM];
    assign next_therm  = therm_set | (ctrl[`QD_CB_THERM] & ~therm_clear);
    assign dac_upd     = ld_fall | clear_fall | (exec & ~ld_n);

    // Control word; a new overtemperature beats a clear
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl <= `QD_CTRL_RESET;
        end else begin
            if (ctrl_wr) begin
                ctrl[`QD_CB_FLOAT] <= wdata[`QD_CB_FLOAT];
                ctrl[`QD_CB_PWR_HI:`QD_CB_PWR_LO] <= wdata[`QD_CB_PWR_HI:`QD_CB_PWR_LO];
            end
            ctrl[`QD_CB_THERM] <= next_therm;
        end
    end

    // Analog controls: shutdown forces every channel off
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            chan_on             <= 4'h0;
            output_float_select <= 1'b1;
            alarm_n             <= 1'b1;
        end else begin
            chan_on <= ctrl[`QD_CB_PWR_HI:`QD_CB_PWR_LO] & {4{~next_therm}};
            output_float_select <= ctrl[`QD_CB_FLOAT];
            alarm_n <= ~next_therm;
        end
    end

    // ***************************************
    // Readback
    // ***************************************
    qd_code_t rd_val, rd_sh;
    // Registers visible to a read frame
    always_comb begin
        case (sh[2:0])
            3'h1, 3'h2, 3'h3, 3'h4: rd_val = in_reg[sh[2:0] - 3'h1];
            `QD_SEL_CTRL: rd_val = {5'h00, ctrl};
            default: rd_val = 12'h000;
        endcase
    end

    // Drive from fifth rise; stop after last bit or on select high
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            serial_dout    <= 1'b0;
            serial_dout_oe <= 1'b0;
            rd_sh          <= 12'h000;
        end else if (fs_n || state != QD_SHIFT || exec) begin
            serial_dout_oe <= 1'b0;
        end else if (sclk_rise && bit_cnt == `QD_RD_START && sh[3]) begin
            serial_dout    <= rd_val[11];
            rd_sh          <= {rd_val[10:0], 1'b0};
            serial_dout_oe <= 1'b1;
        end else if (sclk_rise && serial_dout_oe && bit_cnt != `QD_FRAME_BITS) begin
            serial_dout <= rd_sh[11];
            rd_sh       <= {rd_sh[10:0], 1'b0};
        end
    end

    // ***************************************
    // Register bus slave
    // ***************************************
    logic        ack, req;
    logic [31:0] next_rdata;
    logic [3:0]  ai;

    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack;
    assign ai              = avs_address[5:2];

    // One wait cycle, then the access completes
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ack <= 1'b0;
        end else begin
            ack <= req & ~ack;
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (avs_address)
            `QD_OFS_STATUS: next_rdata = {24'h0, chan_on, 1'b0, rsel,
                                          state != QD_IDLE, ctrl[`QD_CB_THERM]};
            `QD_OFS_CTRL:   next_rdata = {30'h0, temp_test, link_en};
            `QD_OFS_CWORD:  next_rdata = {25'h0, ctrl};
            default: begin
                if (avs_address[7:4] == `QD_OFS_DAC0 >> 4) begin
                    next_rdata = {20'h0, dac_reg[ai[1:0]]};
                end else if (avs_address[7:4] == `QD_OFS_INP0 >> 4) begin
                    next_rdata = {20'h0, in_reg[ai[1:0]]};
                end
            end
        endcase
    end

    // Read data captured in the wait cycle, held to completion
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            avs_readdata <= next_rdata;
        end
    end

    // Software control bits
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            {temp_test, link_en} <= `QD_SW_CTRL_RST;
        end else if (avs_write && ack && avs_address == `QD_OFS_CTRL
                     && avs_byteenable[0]) begin
            {temp_test, link_en} <= avs_writedata[1:0];
        end
    end

    // ***************************************
    // Checks
    // ***************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence rd_start_s;
        state == QD_SHIFT && !fs_n && sclk_rise && bit_cnt == `QD_RD_START && sh[3];
    endsequence
    sequence ld_edge_s;
        ld_fall && !clear_fall;
    endsequence
    shift_msb_a: assert property (
        state == QD_SHIFT && sclk_rise && bit_cnt < `QD_FRAME_BITS && !start
        |=> sh[0] == $past(din) && sh[15:1] == $past(sh[14:0]))
        else $error("shift register did not take data bit");
    exec_hold_a: assert property (
        exec |=> state == QD_HOLD ##1 (state == QD_HOLD || state == QD_IDLE))
        else $error("frame did not close after execute");
    wr_input_a: assert property (
        wr_hit[0] && !clear_fall |=> in_reg[0] == $past(wdata))
        else $error("input register not written");
    dac_private_a: assert property (
        !$stable(dac_reg) |-> $past(dac_upd))
        else $error("output register changed without cause");
    rd_drive_a: assert property (
        rd_start_s |=> serial_dout_oe && serial_dout == $past(rd_val[11]))
        else $error("readback did not start on fifth rise");
    rd_release_a: assert property (
        fs_n || exec |=> !serial_dout_oe)
        else $error("readback still driven after frame");
    clear_a: assert property (
        clear_fall |=> in_reg == '0 && dac_reg == '0)
        else $error("clear did not zero registers");
    load_copy_a: assert property (
        ld_edge_s |=> dac_reg == $past(in_reg))
        else $error("load edge did not copy inputs");
    alarm_set_a: assert property (
        ot |=> !alarm_n && ctrl[`QD_CB_THERM] && chan_on == 4'h0)
        else $error("overtemperature not flagged");
    therm_hold_a: assert property (
        ctrl[`QD_CB_THERM] && !therm_clear |=> ctrl[`QD_CB_THERM] && !alarm_n)
        else $error("thermal flag dropped without clear");
    span_keep_a: assert property (
        !ld_fall && !(|wr_hit) |=> $stable(span_30v))
        else $error("span changed without register update");
endmodule

// ===== hdl/qd_pkg.sv
// Purpose: shared types of the quad DAC serial control block
// Assumes: nothing
// Notes:   constants live in qd_consts.svh
package qd_pkg;
    // Frame tracking states
    typedef enum logic [1:0] {
        QD_IDLE,
        QD_SHIFT,
        QD_HOLD
    } qd_frame_t;
    typedef logic [11:0] qd_code_t;
    typedef logic [2:0]  qd_sel_t;
endpackage

// ===== hdl/qd_sync.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   first stage is read by the second stage only
`timescale 1ns/100ps
module qd_sync #(
    parameter int          W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // Two stages, reset to idle pin levels
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            meta <= RST;
            q    <= RST;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== tb/qd_host_model.sv
// Purpose: host end of the serial link, frame master with readback capture
// Assumes: link clock idles low and runs only inside frames
// Notes:   reads run the link clock slower than writes
`timescale 1ns/100ps
module qd_host_model (
    input  wire logic clock,
    output logic      frame_sel_n,
    output logic      serial_clk,
    output logic      serial_din,
    input  wire logic serial_dout,
    input  wire logic serial_dout_oe
);
    // ***************************************
    // Frame master
    // ***************************************
    // Idle levels of the link at time zero
    initial begin
        frame_sel_n = 1'b1;
        serial_clk  = 1'b0;
        serial_din  = 1'b0;
    end
    // One frame of nbits clocks; a short count raises select early
    task automatic xfer(input logic [15:0] w, input int nbits,
                        output logic [11:0] rd, output logic ok);
        int i;
        int half;
        half = w[15] ? 12 : 8;
        ok = 1'b1;
        rd = 12'h000;
        @(posedge clock);
        frame_sel_n <= 1'b0;
        for (i = 0; i < nbits; i++) begin
            serial_din <= w[15 - i];
            repeat (half) @(posedge clock);
            serial_clk <= 1'b1;
            repeat (half) @(posedge clock);
            if (i >= 4) begin
                rd = {rd[10:0], serial_dout};
            end
            ok &= (serial_dout_oe === (w[15] && i >= 4));
            serial_clk <= 1'b0;
        end
        repeat (half) @(posedge clock);
        ok &= (serial_dout_oe === 1'b0);
        frame_sel_n <= 1'b1;
        serial_din  <= ~serial_din;
        repeat (8) @(posedge clock);
    endtask
endmodule

// ===== tb/quad_dac_serial_control_tb_top.sv
// Purpose: self-checking bench of the quad DAC serial control block
// Assumes: 200 MHz clock, link clock made by the host model
// Notes:   expected codes are worked out here, never read from the design
`timescale 1ns/100ps
`define QD_CHECK(g, e) check_val(32'(g), 32'(e))
module quad_dac_serial_control_tb_top;
    import qd_pkg::*;
    logic             clock = 1'b0;
    logic             rst_b = 1'b0;
    logic [7:0]       avs_address = 8'h00;
    logic             avs_read = 1'b0;
    logic             avs_write = 1'b0;
    logic [31:0]      avs_writedata = 32'h0;
    logic [31:0]      avs_readdata;
    logic             avs_waitrequest;
    logic             frame_sel_n;
    logic             serial_clk;
    logic             serial_din;
    logic             serial_dout;
    logic             serial_dout_oe;
    logic             async_clear_n = 1'b1;
    logic             load_dac_n = 1'b1;
    logic             range_sel = 1'b1;
    logic             over_temp = 1'b0;
    logic             alarm_n;
    qd_code_t [3:0]   dac_code;
    logic [3:0]       span_30v;
    logic [3:0]       chan_on;
    logic             output_float_select;
    int               n_mismatch = 0;
    int               check_count = 0;

    // ***************************************
    // Clock, design and host
    // ***************************************
    // Clock of 5 ns period
    always #2.5 clock = ~clock;

    qd_dac_ctrl i_dut (
        .clock(clock), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .frame_sel_n(frame_sel_n), .serial_clk(serial_clk), .serial_din(serial_din),
        .serial_dout(serial_dout), .serial_dout_oe(serial_dout_oe),
        .async_clear_n(async_clear_n), .load_dac_n(load_dac_n), .range_sel(range_sel),
        .over_temp(over_temp), .alarm_n(alarm_n), .dac_code(dac_code),
        .span_30v(span_30v), .chan_on(chan_on), .output_float_select(output_float_select)
    );

    qd_host_model i_host (
        .clock(clock), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
        .serial_din(serial_din), .serial_dout(serial_dout),
        .serial_dout_oe(serial_dout_oe)
    );

    // ***************************************
    // Shared tasks
    // ***************************************
    // Compare and count
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, g, e);
        end
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic av(input logic we, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
        int i;
        @(posedge clock);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= we;
        avs_read      <= ~we;
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (avs_waitrequest === 1'b0) begin
                break;
            end
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            final_report();
        end
    endtask

    // Full serial frame with output enable timing checked
    task automatic frame(input logic [15:0] w, output logic [11:0] rd);
        logic ok;
        i_host.xfer(w, 16, rd, ok);
        `QD_CHECK(ok, 1'b1);
    endtask

    // ***************************************
    // Scenarios
    // ***************************************
    // Reset state, read-only and unmapped places
    task automatic t_reset;
        logic [31:0] d;
        int          c;
        av(1'b0, 8'h30, 32'h0, d);
        `QD_CHECK(d, 32'h40);
        for (c = 0; c < 4; c++) begin
            `QD_CHECK(dac_code[c], 12'h000);
        end
        `QD_CHECK(alarm_n, 1'b1);
        av(1'b0, 8'h3C, 32'h0, d);
        `QD_CHECK(d, 32'h0);
        av(1'b1, 8'h10, 32'hFFF, d);
        av(1'b0, 8'h10, 32'h0, d);
        `QD_CHECK(d, 32'h0);
        av(1'b1, 8'h04, 32'h1, d);
        av(1'b0, 8'h04, 32'h0, d);
        `QD_CHECK(d[0], 1'b1);
    endtask

    // Channel writes with load high, load edge, serial readback
    task automatic t_write_load;
        logic [31:0] d;
        logic [11:0] rd;
        logic [11:0] code;
        int          c;
        for (c = 0; c < 4; c++) begin
            code = 12'(12'hA05 + c * 12'h111);
            frame({4'(c + 1), code}, rd);
            av(1'b0, 8'(8'h20 + 4 * c), 32'h0, d);
            `QD_CHECK(d, code);
            `QD_CHECK(dac_code[c], 12'h000);
        end
        @(posedge clock);
        load_dac_n <= 1'b0;
        repeat (8) @(posedge clock);
        load_dac_n <= 1'b1;
        repeat (8) @(posedge clock);
        for (c = 0; c < 4; c++) begin
            code = 12'(12'hA05 + c * 12'h111);
            `QD_CHECK(dac_code[c], code);
            frame({1'b1, 3'(c + 1), 12'h000}, rd);
            `QD_CHECK(rd, code);
        end
    endtask

    // Range change, load held low, reserved, idle and cut-short frames
    task automatic t_sync_update;
        logic [11:0] rd;
        logic        ok;
        int          c;
        @(posedge clock);
        range_sel  <= 1'b0;
        repeat (8) @(posedge clock);
        `QD_CHECK(span_30v, 4'hF);
        load_dac_n <= 1'b0;
        frame({4'h5, 12'hC3A}, rd);
        frame({4'h6, 12'h111}, rd);
        frame({4'h0, 12'h222}, rd);
        i_host.xfer({4'h1, 12'h777}, 8, rd, ok);
        for (c = 0; c < 4; c++) begin
            `QD_CHECK(dac_code[c], 12'hC3A);
        end
        `QD_CHECK(span_30v, 4'h0);
        @(posedge clock);
        load_dac_n <= 1'b1;
    endtask

    // Control word, thermal latch and its clearing
    task automatic t_thermal;
        logic [31:0] d;
        logic [11:0] rd;
        frame({4'h7, 12'h03C}, rd);
        frame({4'h0, 12'h000}, rd);
        `QD_CHECK(chan_on, 4'hF);
        `QD_CHECK(output_float_select, 1'b0);
        @(posedge clock);
        over_temp <= 1'b1;
        repeat (10) @(posedge clock);
        over_temp <= 1'b0;
        repeat (10) @(posedge clock);
        `QD_CHECK(alarm_n, 1'b0);
        `QD_CHECK(chan_on, 4'h0);
        av(1'b0, 8'h00, 32'h0, d);
        `QD_CHECK(d[0], 1'b1);
        frame({4'hF, 12'h000}, rd);
        `QD_CHECK(rd, 12'h03D);
        frame({4'h7, 12'h03C}, rd);
        frame({4'h0, 12'h000}, rd);
        `QD_CHECK(alarm_n, 1'b1);
        `QD_CHECK(chan_on, 4'hF);
    endtask

    // Clear pin zeroes input and output codes
    task automatic t_clear;
        logic [31:0] d;
        int          c;
        @(posedge clock);
        async_clear_n <= 1'b0;
        repeat (10) @(posedge clock);
        async_clear_n <= 1'b1;
        repeat (4) @(posedge clock);
        for (c = 0; c < 4; c++) begin
            `QD_CHECK(dac_code[c], 12'h000);
        end
        av(1'b0, 8'h24, 32'h0, d);
        `QD_CHECK(d, 32'h0);
    endtask

    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        t_reset();
        t_write_load();
        t_sync_update();
        t_thermal();
        t_clear();
        final_report();
    end
endmodule
